// File: verilog/volatile_enhanced_config_reg.sv
// volatile enhanced configuration register and its run-time effects
// assumes the command decoder reports quad modify instructions on
// core_clk and the nonvolatile settings are stable during reset
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// [RULE1] completed write replaces power-on configuration
// [RULE2] bit 7 low selects quad protocol
// [RULE3] bit 6 low selects dual protocol
// [RULE4] both low: quad wins
// [RULE5] bit 7 high again: dual or extended
// [RULE6] both protocol bits default high
// [RULE7] bit 4 low disables hold/reset pin
// [RULE8] power-on restores hold unless nonvolatile bit low
// [RULE9] bit 3 high disables accelerating voltage
// [RULE10] accelerator bit only counts for quad modify
// [RULE11] quad falls back until voltage drops again
// [RULE12] fallback still accepts polling and suspend
// [RULE13] voltage late by 200ms: normal speed, flag
// [RULE14] bits 2:0 hold drive strength code
// [RULE15] voltage flag sticks until flag clear
// [RULE16] bit 5 reserved, reads zero
// [RULE17] new protocol starts after deselect
module volatile_enhanced_config_reg
  import vecfg_pkg::*;
#(
  parameter int TIMEOUT_CYC = VPP_TIMEOUT_CYC
) (
  input  wire logic       core_clk,        // core clock, 10 MHz
  input  wire logic       resetn,          // async reset, active low
  input  wire logic       sclk,            // serial link clock
  input  wire logic       cs_n,            // chip select pin, active low
  input  wire logic       din,             // serial data pin
  input  wire logic       vpp_high,        // program voltage at high level
  input  wire logic [7:0] nv_config,       // nonvolatile image, same layout
  input  wire logic       quad_modify_done,// program/erase received
  input  wire logic       quad_op,         // that operation is quad type
  output logic [7:0]      config_rd,       // register read value
  output logic            proto_quad,      // quad protocol active
  output logic            proto_dual,      // dual protocol active
  output logic            ext_fallback,    // temporary extended protocol
  output logic            poll_allowed,    // polling and suspend accepted
  output logic            hold_fn_en,      // hold/reset pin function on
  output logic            accel_en,        // accelerating voltage allowed
  output logic            fast_program,    // modify runs with high voltage
  output logic            vpp_err_flag,    // voltage error flag bit
  output logic [2:0]      drive_code,      // output driver strength code
  output logic            drive_code_bad   // a reserved code is loaded
);
  localparam int TW = $clog2(TIMEOUT_CYC + 1);
  localparam logic [TW-1:0] TLAST = TW'(TIMEOUT_CYC - 1);

  typedef enum logic [2:0] {
    ACC_IDLE = 3'h1,
    ACC_WAIT = 3'h2,
    ACC_HIGH = 3'h4
  } acc_state_t;

  typedef struct packed {
    logic [7:0]    cfg;
    logic [7:0]    staged;
    logic          pending;
    logic          loaded;
    logic          wtog_seen;
    logic          ctog_seen;
    logic          fallback;
    logic          fast;
    logic          err;
    acc_state_t    acc;
    logic [TW-1:0] timer;
  } core_state_t;

  core_state_t st;
  core_state_t next_st;
  logic [1:0]  rst_pipe;
  logic        rst_q;
  logic [7:0]  link_data;
  logic        link_wtog;
  logic        link_clr;
  logic [3:0]  sync_out;
  logic        cs_high;
  logic        vpp_s;
  logic        wtog_s;
  logic        ctog_s;
  logic        wr_event;
  logic        clr_event;
  logic        accel_req;

  // reserved bit forced low on every load
  function automatic logic [7:0] clean_cfg(input logic [7:0] v);
    return v & CFG_WMASK;
  endfunction : clean_cfg

  // reset release through two flip-flops
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_q = rst_pipe[1];

  // serial side capture of the write instruction
  link_capture u_link (
    .sclk    (sclk),
    .rst_n   (resetn),
    .cs_n    (cs_n),
    .din     (din),
    .wr_data (link_data),
    .wr_tog  (link_wtog),
    .clr_tog (link_clr)
  );

  // pins and link toggles enter the core domain
  sync_bits #(
    .WIDTH (4)
  ) u_sync (
    .clk   (core_clk),
    .rst_n (rst_q),
    .d     ({cs_n, vpp_high, link_wtog, link_clr}),
    .q     (sync_out)
  );
  assign {cs_high, vpp_s, wtog_s, ctog_s} = sync_out;

  assign wr_event  = wtog_s ^ st.wtog_seen;
  assign clr_event = ctog_s ^ st.ctog_seen;
  // [RULE10] only quad modify weighs bit 3
  assign accel_req = quad_modify_done & quad_op & ~st.cfg[ACCEL_BIT];

  // next state of the whole register block
  always_comb begin
    next_st = st;
    next_st.wtog_seen = wtog_s;
    next_st.ctog_seen = ctog_s;
    // [RULE8] power-on loads nonvolatile image
    if (!st.loaded) begin
      next_st.cfg    = clean_cfg(nv_config);
      next_st.loaded = 1'b1;
    end
    // the written byte is stable once its toggle is seen
    if (wr_event) begin
      next_st.staged  = link_data;
      next_st.pending = 1'b1;
    end
    // [RULE17] apply only once deselected
    // [RULE1] written byte replaces configuration
    if (st.pending && cs_high && !wr_event) begin
      next_st.cfg     = clean_cfg(st.staged);
      next_st.pending = 1'b0;
    end
    // accelerating-voltage sequence after a quad modify
    case (st.acc)
      ACC_IDLE: begin
        if (accel_req) begin
          next_st.acc      = ACC_WAIT;
          next_st.timer    = '0;
          next_st.fast     = 1'b0;
          // [RULE11] quad steps back to extended
          next_st.fallback = ~st.cfg[QUAD_BIT];
        end
      end
      ACC_WAIT: begin
        next_st.timer = st.timer + TW'(1);
        if (vpp_s) begin
          next_st.acc  = ACC_HIGH;
          next_st.fast = 1'b1;
        end else if (st.timer == TLAST) begin
          // [RULE13] late voltage: normal speed, flag
          next_st.acc      = ACC_IDLE;
          next_st.err      = 1'b1;
          next_st.fallback = 1'b0;
        end
      end
      ACC_HIGH: begin
        if (!vpp_s) begin
          // [RULE11] back to quad after voltage drops
          next_st.acc      = ACC_IDLE;
          next_st.fast     = 1'b0;
          next_st.fallback = 1'b0;
        end
      end
      default: begin
        next_st.acc = ACC_IDLE;
      end
    endcase
    // [RULE15] clear loses to a new error
    if (clr_event && !(st.acc == ACC_WAIT && !vpp_s && st.timer == TLAST))
    begin
      next_st.err = 1'b0;
    end
  end

  // [RULE6] reset leaves both protocol bits high
  always_ff @(posedge core_clk or negedge rst_q) begin
    if (!rst_q) begin
      st          <= '0;
      st.cfg      <= CFG_RESET;
      st.staged   <= CFG_RESET;
      st.acc      <= ACC_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // [RULE16] reserved bit reads zero
  assign config_rd = st.cfg;
  // [RULE2] [RULE4] quad when bit 7 low and no fallback active
  assign proto_quad = ~st.cfg[QUAD_BIT] & ~st.fallback;
  // [RULE3] [RULE5] dual only when quad is off
  assign proto_dual = st.cfg[QUAD_BIT] & ~st.cfg[DUAL_BIT];
  assign ext_fallback = st.fallback;
  // [RULE12] polling and suspend during fallback
  assign poll_allowed = 1'b1;
  // [RULE7] bit 4 low ignores hold/reset
  assign hold_fn_en = st.cfg[HOLD_BIT];
  // [RULE9] bit 3 high blocks the voltage
  assign accel_en = ~st.cfg[ACCEL_BIT];
  assign fast_program = st.fast;
  assign vpp_err_flag = st.err;
  // [RULE14] drive strength code
  assign drive_code = st.cfg[DRV_MSB:0];
  assign drive_code_bad = (drive_code == DRV_RSVD_A)
                        | (drive_code == DRV_RSVD_B);

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_q);

  a_reserved_zero: assert property (config_rd[RSVD_BIT] == 1'b0) // [RULE16]
    else $error("reserved bit reads one");
  a_quad_wins: assert property ( // [RULE4]
    (!st.cfg[QUAD_BIT] && !st.fallback) |-> (proto_quad && !proto_dual))
    else $error("quad not given priority");
  a_dual_select: assert property ( // [RULE3]
    (st.cfg[QUAD_BIT] && !st.cfg[DUAL_BIT]) |-> proto_dual)
    else $error("dual protocol not selected");
  a_apply_deselect: assert property ( // [RULE17]
    $changed(st.cfg) && st.loaded && $past(st.loaded) |->
      $past(cs_high) && $past(st.pending))
    else $error("config changed while selected");
  a_write_applies: assert property ( // [RULE1]
    (st.pending && cs_high && !wr_event) |=>
      st.cfg == clean_cfg($past(st.staged)))
    else $error("write not applied");
  a_hold_follows: assert property ( // [RULE7]
    hold_fn_en == config_rd[HOLD_BIT])
    else $error("hold enable mismatch");
  a_accel_ignored: assert property ( // [RULE9]
    (st.acc == ACC_IDLE && st.cfg[ACCEL_BIT]) |=> st.acc == ACC_IDLE)
    else $error("accelerator used while disabled");
  a_timeout_flag: assert property ( // [RULE13]
    (st.acc == ACC_WAIT && !vpp_s && st.timer == TLAST) |=>
      vpp_err_flag && !fast_program)
    else $error("timeout did not raise flag");
  a_flag_sticks: assert property ( // [RULE15]
    (vpp_err_flag && !clr_event) |=> vpp_err_flag)
    else $error("error flag dropped without clear");
  a_fallback_end: assert property ( // [RULE11]
    (st.acc == ACC_HIGH && !vpp_s) |=> !ext_fallback && !fast_program)
    else $error("fallback not ended on voltage drop");

  // quad selection must silence the dual decode entirely
  // a dual output left on would make the command decoder ambiguous
  a_dual_yield: assert property ( // [RULE4]
    !st.cfg[QUAD_BIT] |-> !proto_dual)
    else $error("dual active while quad selected");

  // both selection bits high leave only the single-line protocol
  // this is also the reset value, replaced by the nonvolatile image on the first clock
  a_ext_default: assert property ( // [RULE5]
    (st.cfg[QUAD_BIT] && st.cfg[DUAL_BIT]) |-> (!proto_quad && !proto_dual))
    else $error("extended protocol not selected");

  // accelerator enable is the inverse of the stored bit
  // the host sees the bit, the program engine sees the enable
  a_accel_follows: assert property ( // [RULE9]
    accel_en == !config_rd[ACCEL_BIT])
    else $error("accelerator enable mismatch");

  // drive code comes straight from the low three bits
  // reserved codes are kept, only flagged, so the pads see them
  a_drive_follows: assert property ( // [RULE14]
    drive_code == config_rd[2:0])
    else $error("drive code mismatch");

  // the reserved-code flag must be set exactly for the two codes
  a_drive_reserved: assert property ( // [RULE14]
    drive_code_bad ==
      ((config_rd[2:0] == DRV_RSVD_A) || (config_rd[2:0] == DRV_RSVD_B)))
    else $error("reserved drive code flag wrong");

  // a quad modify in quad protocol steps back to extended
  // the third data line is busy carrying the program voltage
  a_fallback_start: assert property ( // [RULE11]
    (st.acc == ACC_IDLE && accel_req && !st.cfg[QUAD_BIT]) |=>
      ext_fallback && !proto_quad)
    else $error("fallback not entered");

  // the synchronised voltage lifts the operation to fast mode
  a_fast_on_vpp: assert property ( // [RULE13]
    (st.acc == ACC_WAIT && vpp_s) |=> fast_program)
    else $error("fast program not entered");

  // polling must stay possible while the fallback is active
  a_poll_fallback: assert property ( // [RULE12]
    ext_fallback |-> poll_allowed)
    else $error("polling refused during fallback");

  // first edge after reset loads the nonvolatile image
  // the reserved bit is dropped on the way in
  a_power_load: assert property ( // [RULE8]
    !st.loaded |=> config_rd == clean_cfg($past(nv_config)))
    else $error("power-on image not loaded");

  // a clear with no competing timeout empties the flag
  a_clear_flag: assert property ( // [RULE15]
    (clr_event && vpp_err_flag && st.acc != ACC_WAIT) |=> !vpp_err_flag)
    else $error("flag clear ignored");

  // the wait timer never runs past its last count
  // a wrap here would hide a late voltage forever
  a_timer_bound: assert property ( // [RULE13]
    st.acc == ACC_WAIT |-> st.timer <= TLAST)
    else $error("voltage timer overran");

  // only a quad modify may start the voltage sequence
  a_only_quad: assert property ( // [RULE10]
    (st.acc == ACC_IDLE && !(quad_modify_done && quad_op)) |=>
      st.acc == ACC_IDLE)
    else $error("sequence started without quad modify");

  c_fallback:    cover property ($rose(ext_fallback));
  c_write_done:  cover property (st.pending && cs_high ##1 !st.pending);
  c_fast_run:    cover property (st.acc == ACC_WAIT ##1 st.acc == ACC_HIGH);
  c_timeout:     cover property ($rose(vpp_err_flag));
  c_flag_clear:  cover property ($fell(vpp_err_flag));
endmodule : volatile_enhanced_config_reg
`default_nettype wire

// File: verilog/vecfg_pkg.sv
// constants for the volatile enhanced configuration register block
// assumes a 10 MHz core clock and a serial link clocked by the host
package vecfg_pkg;
  // field positions inside the configuration byte
  localparam int QUAD_BIT  = 7;
  localparam int DUAL_BIT  = 6;
  localparam int RSVD_BIT  = 5;
  localparam int HOLD_BIT  = 4;
  localparam int ACCEL_BIT = 3;
  localparam int DRV_MSB   = 2;
  // value after reset: quad, dual and accelerator off, hold on, reserved bit low, 30 ohm drive
  localparam logic [7:0] CFG_RESET = 8'hDF;
  // writable bits; the reserved bit always reads zero
  localparam logic [7:0] CFG_WMASK = 8'hDF;
  // drive strength codes that must not be used
  localparam logic [2:0] DRV_RSVD_A = 3'h0;
  localparam logic [2:0] DRV_RSVD_B = 3'h4;
  localparam logic [2:0] DRV_DEFAULT = 3'h7;
  // instruction codes, arbitrary values
  localparam logic [7:0] OP_WRITE_CFG = 8'h61;
  localparam logic [7:0] OP_CLEAR_FLAG = 8'h50;
  // serial frame length of the register write
  localparam logic [4:0] BITS_OPCODE = 5'h08;
  localparam logic [4:0] BITS_WRITE  = 5'h10;
  // time allowed to raise the program voltage after deselect
  localparam longint VPP_TIMEOUT_MS = 200;
  localparam longint CORE_CLK_HZ    = 10000000;
  localparam int VPP_TIMEOUT_CYC =
    int'((VPP_TIMEOUT_MS * CORE_CLK_HZ) / 1000);
endpackage : vecfg_pkg

// File: verilog/sync_bits.sv
// two-stage synchroniser for a group of independent levels
// assumes each bit is a level that stays put for several clocks
`timescale 1ns/1ps
`default_nettype none
module sync_bits #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,    // destination clock
  input  wire logic             rst_n,  // async reset, active low
  input  wire logic [WIDTH-1:0] d,      // levels from another domain
  output logic      [WIDTH-1:0] q       // synchronised levels
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_state_t;

  sync_state_t st;
  sync_state_t next_st;

  // first stage feeds only the second
  always_comb begin
    next_st.meta   = d;
    next_st.stable = st.meta;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign q = st.stable;
endmodule : sync_bits
`default_nettype wire

// File: verilog/link_capture.sv
// serial-clock front end: takes the opcode and the data byte
// assumes single-line input sampled on the rising serial clock edge
`timescale 1ns/1ps
`default_nettype none
module link_capture
  import vecfg_pkg::*;
(
  input  wire logic       sclk,      // serial link clock
  input  wire logic       rst_n,     // async reset, active low
  input  wire logic       cs_n,      // chip select, active low
  input  wire logic       din,       // serial data in
  output logic [7:0]      wr_data,   // last byte written to config
  output logic            wr_tog,    // flips on each complete write
  output logic            clr_tog    // flips on each flag clear
);
  typedef struct packed {
    logic [4:0] cnt;
    logic [7:0] shift;
    logic [7:0] opcode;
  } frame_state_t;

  typedef struct packed {
    logic [7:0] data;
    logic       wtog;
    logic       ctog;
  } held_state_t;

  frame_state_t fr;
  frame_state_t next_fr;
  held_state_t  hd;
  held_state_t  next_hd;
  logic [7:0]   byte_in;

  // shift in one bit per edge, counting up to the write length
  always_comb begin
    byte_in = {fr.shift[6:0], din};
    next_fr = fr;
    next_fr.shift = byte_in;
    if (fr.cnt != BITS_WRITE) begin
      next_fr.cnt = fr.cnt + 5'h01;
    end
    if (fr.cnt == (BITS_OPCODE - 5'h01)) begin
      next_fr.opcode = byte_in;
    end
  end

  // deselect ends the frame without needing a clock edge
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      fr <= '0;
    end else begin
      fr <= next_fr;
    end
  end

  // completed instructions are reported by toggles
  always_comb begin
    next_hd = hd;
    if (fr.cnt == (BITS_WRITE - 5'h01) && fr.opcode == OP_WRITE_CFG) begin
      next_hd.data = byte_in;
      next_hd.wtog = ~hd.wtog;
    end
    if (fr.cnt == (BITS_OPCODE - 5'h01) && byte_in == OP_CLEAR_FLAG) begin
      next_hd.ctog = ~hd.ctog;
    end
  end

  always_ff @(posedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      hd <= '0;
    end else begin
      hd <= next_hd;
    end
  end

  assign wr_data = hd.data;
  assign wr_tog  = hd.wtog;
  assign clr_tog = hd.ctog;
endmodule : link_capture
`default_nettype wire

// File: sim/spi_host_model.sv
// serial host model: sends one instruction frame per start request
// assumes the bench holds frame and nbits steady while busy is high
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  input  wire logic        start,  // rising edge begins one frame
  input  wire logic [15:0] frame,  // frame bits, msb first
  input  wire logic [4:0]  nbits,  // number of bits to shift
  output logic             sclk,   // link clock, still between frames
  output logic             cs_n,   // chip select, active low
  output logic             din,    // serial data to the device
  output logic             busy    // frame in progress
);
  int k;

  // idle levels at time zero
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    din = 1'b0;
    busy = 1'b0;
  end

  // select, shift msb first at 15 ns per bit, then deselect
  always @(posedge start) begin
    busy = 1'b1;
    cs_n = 1'b0;
    #20;
    for (k = 0; k < nbits; k++) begin
      din = frame[15-k];
      #7.5 sclk = 1'b1;
      #7.5 sclk = 1'b0;
    end
    #10;
    cs_n = 1'b1;
    din = ~din;   // a released line never keeps the last bit
    busy = 1'b0;
  end
endmodule : spi_host_model
`default_nettype wire

// File: sim/volatile_enhanced_config_reg_bench.sv
// self-checking bench for the volatile enhanced configuration register
// assumes the host model drives the link; checks go through a queue
`timescale 1ns/1ps
`default_nettype none
module volatile_enhanced_config_reg_bench
  import vecfg_pkg::*;
;
  localparam int TMO = 50;
  logic        core_clk, resetn, sclk, cs_n, din, vpp_high;
  logic        quad_modify_done, quad_op, start, busy, chk;
  logic        proto_quad, proto_dual, ext_fallback, poll_allowed;
  logic        hold_fn_en, accel_en, fast_program, vpp_err_flag;
  logic        drive_code_bad;
  logic [2:0]  drive_code;
  logic [7:0]  nv_config, config_rd, cur, d, n;
  logic [15:0] frame;
  logic [4:0]  nbits;
  logic [19:0] expq[$];
  logic [19:0] e;
  logic        err;
  int          failures, cmp_count, cyc, i;

  volatile_enhanced_config_reg #(.TIMEOUT_CYC(TMO)) DUT (
    .core_clk(core_clk), .resetn(resetn), .sclk(sclk), .cs_n(cs_n),
    .din(din), .vpp_high(vpp_high), .nv_config(nv_config),
    .quad_modify_done(quad_modify_done), .quad_op(quad_op),
    .config_rd(config_rd), .proto_quad(proto_quad),
    .proto_dual(proto_dual), .ext_fallback(ext_fallback),
    .poll_allowed(poll_allowed), .hold_fn_en(hold_fn_en),
    .accel_en(accel_en), .fast_program(fast_program),
    .vpp_err_flag(vpp_err_flag), .drive_code(drive_code),
    .drive_code_bad(drive_code_bad));

  spi_host_model host (
    .start(start), .frame(frame), .nbits(nbits), .sclk(sclk),
    .cs_n(cs_n), .din(din), .busy(busy));

  // core clock, 100 ns period
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // expected outputs from a configuration byte and sequence state
  function automatic logic [19:0] ex(logic [7:0] c, logic fb, fp, er);
    logic [7:0] m;
    m = c & CFG_WMASK;
    ex = {m, ~m[7] & ~fb, m[7] & ~m[6], fb, m[4], ~m[3], fp, er, m[2:0],
          (m[2:0] == DRV_RSVD_A) || (m[2:0] == DRV_RSVD_B), 1'b1};
  endfunction : ex

  task automatic report_and_stop;
    $display("counts: %0d compares, %0d mismatches", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop

  // note an expectation, then strobe the watcher for one cycle
  task automatic check(logic [19:0] x);
    expq.push_back(x);
    @(negedge core_clk) chk <= 1'b1;
    @(negedge core_clk) chk <= 1'b0;
  endtask : check

  // hand one frame to the host model and wait for it to finish
  task automatic send(logic [15:0] f, logic [4:0] nb);
    int w;
    @(negedge core_clk);
    frame <= f;
    nbits <= nb;
    start <= 1'b1;
    for (w = 0; w < 20 && busy !== 1'b1; w++) @(negedge core_clk);
    start <= 1'b0;
    for (w = 0; w < 20 && busy !== 1'b0; w++) @(negedge core_clk);
    repeat (10) @(negedge core_clk);
  endtask : send

  task automatic wr(logic [7:0] v);
    send({OP_WRITE_CFG, v}, BITS_WRITE);
    cur = v;
  endtask : wr

  // reset with a given nonvolatile image, look inside and after
  task automatic do_reset(logic [7:0] v);
    @(negedge core_clk);
    resetn <= 1'b0;
    nv_config <= v;
    repeat (10) @(negedge core_clk);
    check(ex(CFG_RESET, 1'b0, 1'b0, 1'b0));
    repeat (10) @(negedge core_clk);
    resetn <= 1'b1;
    repeat (6) @(negedge core_clk);
    cur = v;
    err = 1'b0;
    check(ex(cur, 1'b0, 1'b0, 1'b0));
  endtask : do_reset

  // one-cycle modify report from the command side
  task automatic pulse(logic q);
    @(negedge core_clk);
    quad_modify_done <= 1'b1;
    quad_op <= q;
    @(negedge core_clk);
    quad_modify_done <= 1'b0;
    repeat (2) @(negedge core_clk);
  endtask : pulse

  // watcher: compare settled outputs on the falling edge
  always @(negedge core_clk) begin
    if (chk === 1'b1) begin
      e = expq.pop_front();
      cmp_count++;
      if ({config_rd, proto_quad, proto_dual, ext_fallback, hold_fn_en,
           accel_en, fast_program, vpp_err_flag, drive_code,
           drive_code_bad, poll_allowed} !== e) begin
        failures++;
        $display("unexpected outputs: expected %h seen %h", e,
                 {config_rd, proto_quad, proto_dual, ext_fallback,
                  hold_fn_en, accel_en, fast_program, vpp_err_flag,
                  drive_code, drive_code_bad, poll_allowed});
      end
    end
  end

  // hang guard
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 6000) begin
      failures++;
      report_and_stop();
    end
  end

  // main sequence
  initial begin
    resetn = 1'b0;
    vpp_high = 1'b0;
    quad_modify_done = 1'b0;
    quad_op = 1'b0;
    start = 1'b0;
    chk = 1'b0;
    frame = 16'h0000;
    nbits = 5'h00;
    nv_config = 8'hFF;
    failures = 0;
    cmp_count = 0;
    cyc = 0;
    void'($urandom(32'h71243F81));
    do_reset(8'hFF);
    for (i = 0; i < 2; i++) begin
      n = 8'($urandom);
      n[HOLD_BIT] = i[0];
      wr(~n);
      check(ex(cur, 1'b0, 1'b0, 1'b0));
      do_reset(n);
    end
    $display("test power-on finished");
    // every drive code and every protocol pair, bit 5 random
    for (i = 0; i < 8; i++) begin
      d = 8'($urandom);
      d[2:0] = i[2:0];
      d[7:6] = i[1:0];
      wr(d);
      check(ex(cur, 1'b0, 1'b0, 1'b0));
    end
    check(ex(cur, 1'b0, 1'b0, 1'b0));
    send({OP_WRITE_CFG, ~cur}, 5'h0F);
    check(ex(cur, 1'b0, 1'b0, 1'b0));
    $display("test config writes finished");
    // host clears bit 3 before quad modify
    wr(8'h67);
    pulse(1'b1);
    check(ex(cur, 1'b1, 1'b0, 1'b0));
    vpp_high <= 1'b1;
    repeat (6) @(negedge core_clk);
    check(ex(cur, 1'b1, 1'b1, 1'b0));
    vpp_high <= 1'b0;
    repeat (6) @(negedge core_clk);
    check(ex(cur, 1'b0, 1'b0, 1'b0));
    pulse(1'b0);
    check(ex(cur, 1'b0, 1'b0, 1'b0));
    $display("test accelerator finished");
    pulse(1'b1);
    repeat (TMO + 10) @(negedge core_clk);
    check(ex(cur, 1'b0, 1'b0, 1'b1));
    wr(8'h7F);
    pulse(1'b1);
    check(ex(cur, 1'b0, 1'b0, 1'b1));
    // host clears the flag after the quad modify with bit 3 high
    send({OP_CLEAR_FLAG, 8'h00}, BITS_OPCODE);
    check(ex(cur, 1'b0, 1'b0, 1'b0));
    $display("test voltage timeout finished");
    report_and_stop();
  end
endmodule : volatile_enhanced_config_reg_bench
`default_nettype wire
